//--- design/uarx_pkg.sv
// uarx_pkg: constants shared by the asynchronous receive recovery block.
// assumes a 32-bit AXI4-Lite register bus and one system clock.
package uarx_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_RX_DATA    = 8'h04;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_CLEAR  = 8'h0c;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h10;
  localparam logic [7:0] OFS_STATE      = 8'h14;

  // control register fields
  localparam int CTRL_ENABLE_BIT  = 0;
  localparam int CTRL_DSPEED_BIT  = 1;
  localparam int CTRL_FBITS_LSB   = 4;
  localparam int CTRL_FBITS_MSB   = 7;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0080;

  // receive data register fields
  localparam int RXD_FE_BIT    = 16;
  localparam int RXD_VALID_BIT = 31;

  // interrupt status bits
  localparam int IRQ_W           = 4;
  localparam int IRQ_FRAME_DONE  = 0;
  localparam int IRQ_FRAME_ERR   = 1;
  localparam int IRQ_NOISE       = 2;
  localparam int IRQ_OVERRUN     = 3;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;

  // sampling geometry
  localparam logic [4:0] SAMPLES_NORMAL = 5'd16;
  localparam logic [4:0] SAMPLES_DOUBLE = 5'd8;
  localparam logic [4:0] VOTE_FIRST_NORMAL = 5'd8;
  localparam logic [4:0] VOTE_FIRST_DOUBLE = 5'd4;
  localparam logic [3:0] FRAME_BITS_MIN = 4'd5;
  localparam logic [3:0] FRAME_BITS_MAX = 4'd10;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // receiver states, gray along idle -> start -> bits -> stop
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_START = 2'b01,
    ST_BITS  = 2'b11,
    ST_STOP  = 2'b10
  } uarx_state_t;

endpackage : uarx_pkg

//--- design/uarx_sync2.sv
// uarx_sync2: two-flop synchroniser for one level.
// assumes d may change at any time; the first stage feeds only the second.
`timescale 1ns/1ps
`default_nettype none
module uarx_sync2 #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic d,
  output var  logic q
);

  logic meta;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta <= RESET_VAL;
      q    <= RESET_VAL;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule : uarx_sync2
`default_nettype wire

//--- design/uarx_top.sv
// uarx_top: asynchronous receive clock and data recovery with axi4-lite registers.
// assumes sample_tick is a one-cycle pulse from an external baud generator at
// 16x (normal) or 8x (double speed) the bit rate, and rstn is asynchronous.
`timescale 1ns/1ps
`default_nettype none
module uarx_top import uarx_pkg::*; #(
  parameter int ADDR_W = 8
) (
  input  wire logic              clock,
  input  wire logic              rstn,
  input  wire logic              sample_tick,
  input  wire logic              serial_rx_line,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output var  logic              irq,
  output var  logic [9:0]        char_data,
  output var  logic              char_frame_error_flag,
  output var  logic              char_strobe
);

  function automatic logic majority3(input logic [2:0] v);
    majority3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction : majority3

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0]  strb);
    logic [31:0] r;
    r = old_val;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    merge_bytes = r;
  endfunction : merge_bytes

  // reset release through two flops
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  logic line_sync;

  uarx_sync2 #(.RESET_VAL(1'b1)) u_line_sync (
    .clock (clock),
    .rst_n (rst_n),
    .d     (serial_rx_line),
    .q     (line_sync)
  );

  // register state
  logic [31:0]      ctrl;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_en;
  logic [9:0]       hold_data;
  logic             hold_fe;
  logic             hold_valid;

  // receiver state
  uarx_state_t state;
  logic [4:0]  samp;
  logic [3:0]  bit_idx;
  logic [1:0]  votes;
  logic [9:0]  shreg;
  logic        prev_line;
  logic        stop_voted;

  // mode decode
  wire logic       rx_enable  = ctrl[CTRL_ENABLE_BIT];
  wire logic       dspeed     = ctrl[CTRL_DSPEED_BIT];
  wire logic [3:0] fbits_raw  = ctrl[CTRL_FBITS_MSB:CTRL_FBITS_LSB];
  wire logic [3:0] fbits      = (fbits_raw < FRAME_BITS_MIN) ? FRAME_BITS_MIN :
                                (fbits_raw > FRAME_BITS_MAX) ? FRAME_BITS_MAX :
                                fbits_raw;
  wire logic [4:0] samp_per_bit = dspeed ? SAMPLES_DOUBLE : SAMPLES_NORMAL;
  wire logic [4:0] vote_first   = dspeed ? VOTE_FIRST_DOUBLE : VOTE_FIRST_NORMAL;
  wire logic [4:0] vote_last    = vote_first + 5'd2;

  // number of the sample taken at this tick
  wire logic [4:0] samp_now = (samp == samp_per_bit) ? 5'd1 : samp + 5'd1;
  wire logic       in_vote  = (samp_now >= vote_first) && (samp_now < vote_last);
  wire logic       at_vote  = (samp_now == vote_last);
  wire logic       bit_val  = majority3({votes, line_sync});
  wire logic       at_end   = (samp_now == samp_per_bit);
  wire logic       fall     = prev_line && !line_sync;
  // double speed holds the stop state one sample beyond the last vote
  wire logic       stop_done = dspeed ? (samp_now == vote_last + 5'd1) : at_vote;

  // right-align the shifted-in bits for the selected frame length
  wire logic [9:0] aligned = shreg >> (4'd10 - fbits);

  // events from the recovery logic
  wire logic ev_frame  = rx_enable && sample_tick && (state == ST_STOP) && at_vote;
  wire logic ev_fe     = ev_frame && !bit_val;
  wire logic ev_noise  = rx_enable && sample_tick && (state == ST_START) && at_vote
                         && bit_val;
  wire logic ev_over   = ev_frame && hold_valid;

  uarx_state_t next_state;

  always_comb begin
    next_state = state;
    if (!rx_enable) begin
      next_state = ST_IDLE;
    end else if (sample_tick) begin
      case (state)
        ST_IDLE: begin
          if (fall) begin
            next_state = ST_START;
          end
        end
        ST_START: begin
          if (at_vote && bit_val) begin
            next_state = ST_IDLE;
          end else if (at_end) begin
            next_state = ST_BITS;
          end
        end
        ST_BITS: begin
          if (at_end && (bit_idx == fbits - 4'd1)) begin
            next_state = ST_STOP;
          end
        end
        ST_STOP: begin
          if (stop_done) begin
            next_state = ST_IDLE;
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // sample counter, voting samples and bit shifter; all advance on ticks only
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      samp       <= 5'd0;
      bit_idx    <= 4'd0;
      votes      <= 2'b11;
      shreg      <= 10'h000;
      prev_line  <= 1'b1;
      stop_voted <= 1'b0;
    end else if (!rx_enable) begin
      samp      <= 5'd0;
      bit_idx   <= 4'd0;
      prev_line <= 1'b1;
    end else if (sample_tick) begin
      prev_line <= line_sync;
      if (state == ST_IDLE) begin
        samp    <= 5'd1;
        bit_idx <= 4'd0;
      end else begin
        samp <= samp_now;
      end
      if (in_vote) begin
        votes <= {votes[0], line_sync};
      end
      if ((state == ST_BITS) && at_vote) begin
        shreg <= {bit_val, shreg[9:1]};
      end
      if ((state == ST_BITS) && at_end) begin
        bit_idx <= bit_idx + 4'd1;
      end
      stop_voted <= (state == ST_STOP) && at_vote;
    end
  end

  // holding register: character and its frame error travel together
  wire logic rd_take   = s_axi_arvalid && s_axi_arready;
  wire logic rd_rxdata = rd_take && (s_axi_araddr[7:0] == OFS_RX_DATA);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hold_data  <= 10'h000;
      hold_fe    <= 1'b0;
      hold_valid <= 1'b0;
    end else if (ev_frame) begin
      hold_data  <= aligned;
      hold_fe    <= ev_fe;
      hold_valid <= 1'b1;
    end else if (rd_rxdata || !rx_enable) begin
      hold_valid <= 1'b0;
    end
  end

  // character stream outputs
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      char_data             <= 10'h000;
      char_frame_error_flag <= 1'b0;
      char_strobe           <= 1'b0;
    end else begin
      char_strobe <= ev_frame;
      if (ev_frame) begin
        char_data             <= aligned;
        char_frame_error_flag <= ev_fe;
      end
    end
  end

  // axi write path: address and data taken in either order
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic              aw_held;
  logic              w_held;

  wire logic       wr_go   = aw_held && w_held && !s_axi_bvalid;
  wire logic [7:0] wr_ofs  = aw_addr_q[7:0];
  wire logic       wr_ctrl = wr_go && (wr_ofs == OFS_CTRL);
  wire logic       wr_clr  = wr_go && (wr_ofs == OFS_IRQ_CLEAR);
  wire logic       wr_en   = wr_go && (wr_ofs == OFS_IRQ_ENABLE);
  wire logic       wr_ok   = (wr_ofs == OFS_CTRL) || (wr_ofs == OFS_IRQ_CLEAR) ||
                             (wr_ofs == OFS_IRQ_ENABLE);
  wire logic [31:0] ctrl_new = merge_bytes(ctrl, w_data_q, w_strb_q);
  wire logic [31:0] clr_new  = merge_bytes(32'h0000_0000, w_data_q, w_strb_q);
  wire logic [31:0] en_new   = merge_bytes({{(32-IRQ_W){1'b0}}, irq_en}, w_data_q, w_strb_q);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr_q     <= '0;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
    end else begin
      if (!aw_held && !s_axi_bvalid && !s_axi_awready) begin
        s_axi_awready <= 1'b1;
      end
      if (!w_held && !s_axi_bvalid && !s_axi_wready) begin
        s_axi_wready <= 1'b1;
      end
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_q     <= s_axi_awaddr;
        aw_held       <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        w_held       <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // software-written registers: ctrl steers the recovery logic, irq_en masks irq
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl   <= CTRL_RESET;
      irq_en <= IRQ_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl <= ctrl_new;
      end
      if (wr_en) begin
        irq_en <= en_new[IRQ_W-1:0];
      end
    end
  end

  // sticky events: a set in the clearing cycle survives
  wire logic [IRQ_W-1:0] irq_set = {ev_over, ev_noise, ev_fe, ev_frame};
  wire logic [IRQ_W-1:0] irq_clr = wr_clr ? clr_new[IRQ_W-1:0] : {IRQ_W{1'b0}};

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat <= IRQ_RESET;
      irq      <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      irq      <= |(irq_stat & irq_en);
    end
  end

  // axi read path
  wire logic [7:0]  rd_ofs = s_axi_araddr[7:0];
  wire logic [31:0] rxd_word = {hold_valid, 14'h0000, hold_fe, 6'h00, hold_data};
  wire logic [31:0] state_word = {16'h0000, stop_voted, 3'h0, bit_idx, 1'b0, samp,
                                  state};
  wire logic [31:0] rd_mux =
    (rd_ofs == OFS_CTRL)       ? ctrl :
    (rd_ofs == OFS_RX_DATA)    ? rxd_word :
    (rd_ofs == OFS_IRQ_STATUS) ? {{(32-IRQ_W){1'b0}}, irq_stat} :
    (rd_ofs == OFS_IRQ_ENABLE) ? {{(32-IRQ_W){1'b0}}, irq_en} :
    (rd_ofs == OFS_STATE)      ? state_word : 32'h0000_0000;
  wire logic rd_ok = (rd_ofs == OFS_CTRL) || (rd_ofs == OFS_RX_DATA) ||
                     (rd_ofs == OFS_IRQ_STATUS) || (rd_ofs == OFS_IRQ_CLEAR) ||
                     (rd_ofs == OFS_IRQ_ENABLE) || (rd_ofs == OFS_STATE);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      if (!s_axi_rvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
      end
      if (rd_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_mux;
        s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : uarx_top
`default_nettype wire

//--- bench/uarx_top_chk.sv
// uarx_top_chk: port-level assertions for the receive recovery block.
// assumes it is bound to uarx_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module uarx_top_chk import uarx_pkg::*; (
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic        sample_tick,
  input wire logic        serial_rx_line,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        irq,
  input wire logic [9:0]  char_data,
  input wire logic        char_frame_error_flag,
  input wire logic        char_strobe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  logic [1:0] sy;
  logic [2:0] vote;
  logic [7:0] hi_ticks;
  logic       stop_one;
  // own copy of the line synchroniser, so the stop vote can be redone here
  assign stop_one = (vote[0] & vote[1]) | (vote[1] & vote[2]) | (vote[0] & vote[2]);
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sy <= 2'b11;
      vote <= 3'b111;
      hi_ticks <= 8'h00;
    end else begin
      sy <= {sy[0], serial_rx_line};
      if (sample_tick) begin
        vote <= {vote[1:0], sy[1]};
        hi_ticks <= !sy[1] ? 8'h00 : (hi_ticks == 8'hff) ? hi_ticks : hi_ticks + 8'h01;
      end
    end
  end
  a_strobe_pulse: assert property (char_strobe |=> !char_strobe)
    else $error("char_strobe longer than one cycle");
  a_strobe_tick: assert property (char_strobe |-> $past(sample_tick))
    else $error("char_strobe not one clock after a sample tick");
  a_stop_vote: assert property (char_strobe |-> char_frame_error_flag == !stop_one)
    else $error("frame error flag disagrees with stop bit vote");
  a_char_stands: assert property ($changed({char_data, char_frame_error_flag}) |-> char_strobe)
    else $error("character outputs changed without a strobe");
  // a character needs a low start sample within one longest frame
  a_start_seen: assert property (char_strobe |-> hi_ticks <= 8'd180)
    else $error("character without a preceding start bit");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
                                   && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
                                 && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
                                 && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read response dropped");
  c_frame_err: cover property (char_strobe && char_frame_error_flag);
  c_irq: cover property (irq);
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule : uarx_top_chk
bind uarx_top uarx_top_chk u_uarx_top_chk (
  .clock, .rstn, .sample_tick, .serial_rx_line, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .irq, .char_data, .char_frame_error_flag, .char_strobe
);
`default_nettype wire

//--- bench/uarx_tx_model.sv
// uarx_tx_model: remote asynchronous transmitter driving the receive line.
// assumes sample_tick paces each sample cell; the line idles high.
`timescale 1ns/1ps
`default_nettype none
module uarx_tx_model (
  input  wire logic clock,
  input  wire logic sample_tick,
  output var  logic line
);
  initial line = 1'b1;
  // one sample cell, changed just after a tick edge
  task automatic tk(input logic v);
    do @(posedge clock); while (sample_tick !== 1'b1);
    line <= v;
  endtask : tk
  // cells counted in ticks, so the bit rate is exact and inside tolerance
  task automatic send(input logic [9:0] d, input int nb, input int spb,
                      input logic stp, input int stop_len, input logic glitch);
    logic b;
    for (int i = -1; i <= nb; i++) begin
      b = (i < 0) ? 1'b0 : (i == nb) ? stp : d[i];
      for (int s = 1; s <= ((i == nb) ? stop_len : spb); s++) begin
        tk((glitch && s == spb / 2 + 1) ? ~b : b);
      end
    end
    if (!stp) begin
      tk(1'b1);
    end
  endtask : send
  task automatic noise(input int n);
    repeat (n) tk(1'b0);
    tk(1'b1);
  endtask : noise
endmodule : uarx_tx_model
`default_nettype wire

//--- bench/uarx_async_rx_recovery_test.sv
// uarx_async_rx_recovery_test: register and serial scenarios for uarx_top.
// assumes a sample tick every 4 clocks and the remote transmitter model.
`timescale 1ns/1ps
`default_nettype none
module uarx_async_rx_recovery_test import uarx_pkg::*;;
  logic clock = 1'b0, rstn = 1'b0, sample_tick = 1'b0;
  wire logic serial_rx_line;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, tcnt = 2'h0;
  logic irq, char_frame_error_flag, char_strobe;
  logic [9:0] char_data;
  logic [10:0] q[$];
  int errors = 0, n_compared = 0;
  uarx_top u_uarx_top (
    .clock, .rstn, .sample_tick, .serial_rx_line, .s_axi_awaddr,
    .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .irq, .char_data, .char_frame_error_flag, .char_strobe
  );
  uarx_tx_model u_uarx_tx_model (.clock, .sample_tick, .line(serial_rx_line));
  always #50 clock = ~clock;
  always @(posedge clock) begin
    tcnt <= tcnt + 2'h1;
    sample_tick <= (tcnt == 2'h3);
    if (char_strobe === 1'b1) q.push_back({char_frame_error_flag, char_data});
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (aw || w) begin
      @(posedge clock);
      aw = aw && s_axi_awready !== 1'b1;
      w = w && s_axi_wready !== 1'b1;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    while (s_axi_bvalid !== 1'b1) @(posedge clock);
    // ready held back one cycle so the response has to stand
    s_axi_bready <= 1'b1;
    @(posedge clock);
    s_axi_bready <= 1'b0;
    check(32'(s_axi_bresp), 32'(er));
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clock); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clock); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b1;
    @(posedge clock);
    s_axi_rready <= 1'b0;
    check(s_axi_rdata, exp);
    check(32'(s_axi_rresp), 32'(er));
  endtask : rd
  task automatic chk_char(input logic [10:0] exp);
    logic [10:0] got;
    repeat (4) @(posedge clock);
    got = (q.size() > 0) ? q.pop_front() : 11'h7ff;
    check(32'(got), 32'(exp));
  endtask : chk_char
  task automatic irq_is(input logic v);
    repeat (2) @(posedge clock);
    check(32'(irq), 32'(v));
  endtask : irq_is
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report
  initial begin
    #4_000_000;
    errors++;
    final_report();
  end
  initial begin
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    rd(OFS_CTRL, CTRL_RESET, RESP_OKAY);
    rd(OFS_IRQ_STATUS, 32'h0, RESP_OKAY);
    rd(8'h18, 32'h0, RESP_SLVERR);
    wr(8'h02, 32'h1, RESP_SLVERR);
    $display("test registers done");
    // one centre sample of every bit is flipped
    for (int d = 5; d <= 10; d++) begin
      wr(OFS_CTRL, {24'h0, 4'(d), 4'h1}, RESP_OKAY);
      u_uarx_tx_model.send(10'h2b5, d, 16, 1'b1, 16, 1'b1);
      chk_char({1'b0, 10'h2b5 & 10'((1 << d) - 1)});
    end
    rd(OFS_RX_DATA, 32'h8000_02b5, RESP_OKAY);
    rd(OFS_IRQ_STATUS, 32'h9, RESP_OKAY);
    wr(OFS_IRQ_CLEAR, 32'hf, RESP_OKAY);
    $display("test lengths done");
    wr(OFS_CTRL, 32'h81, RESP_OKAY);
    wr(OFS_IRQ_ENABLE, 32'h2, RESP_OKAY);
    rd(OFS_IRQ_ENABLE, 32'h2, RESP_OKAY);
    u_uarx_tx_model.send(10'h03c, 8, 16, 1'b0, 16, 1'b0);
    chk_char({1'b1, 10'h03c});
    irq_is(1'b1);
    rd(OFS_RX_DATA, 32'h8001_003c, RESP_OKAY);
    wr(OFS_IRQ_CLEAR, 32'h2, RESP_OKAY);
    irq_is(1'b0);
    wr(OFS_IRQ_ENABLE, 32'h0, RESP_OKAY);
    u_uarx_tx_model.send(10'h0c3, 8, 16, 1'b0, 16, 1'b0);
    chk_char({1'b1, 10'h0c3});
    irq_is(1'b0);
    rd(OFS_IRQ_STATUS, 32'h3, RESP_OKAY);
    wr(OFS_IRQ_CLEAR, 32'hf, RESP_OKAY);
    $display("test frame error done");
    u_uarx_tx_model.noise(7);
    repeat (800) @(posedge clock);
    check(32'(q.size()), 32'h0);
    rd(OFS_IRQ_STATUS, 32'h4, RESP_OKAY);
    u_uarx_tx_model.noise(9);
    repeat (800) @(posedge clock);
    chk_char({1'b0, 10'h0ff});
    $display("test noise done");
    // next start falls on the cell right after the last stop vote
    u_uarx_tx_model.send(10'h055, 8, 16, 1'b1, 10, 1'b0);
    u_uarx_tx_model.send(10'h0aa, 8, 16, 1'b1, 16, 1'b0);
    chk_char({1'b0, 10'h055});
    chk_char({1'b0, 10'h0aa});
    $display("test early start done");
    wr(OFS_CTRL, 32'h83, RESP_OKAY);
    u_uarx_tx_model.send(10'h0a6, 8, 8, 1'b1, 7, 1'b1);
    u_uarx_tx_model.send(10'h059, 8, 8, 1'b1, 8, 1'b1);
    chk_char({1'b0, 10'h0a6});
    chk_char({1'b0, 10'h059});
    // a low at stop sample 7 in double speed must not open a frame
    u_uarx_tx_model.send(10'h0a6, 8, 8, 1'b1, 6, 1'b0);
    u_uarx_tx_model.noise(8);
    repeat (480) @(posedge clock);
    chk_char({1'b0, 10'h0a6});
    check(32'(q.size()), 32'h0);
    $display("test double speed done");
    // disabling drops the valid flag and parks the recovery logic
    wr(OFS_CTRL, 32'h82, RESP_OKAY);
    rd(OFS_RX_DATA, 32'h0000_00a6, RESP_OKAY);
    rd(OFS_STATE, 32'h0, RESP_OKAY);
    $display("test disable done");
    final_report();
  end
endmodule : uarx_async_rx_recovery_test
`default_nettype wire
